// ---- src/pgc_top.v ----
// per-port packet generator and crc checker with apb register access
//
// Chosen here: the APB slave port.
`include "pgc_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module pgc_top #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  input wire ref_clk, // 125 MHz clock
  input wire reset, // sync reset, active high
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb direction
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata, // apb read data
  output reg pready, // apb ready
  output reg pslverr, // apb error on unmapped address
  output reg [7:0] tx_data, // generated byte to copper side
  output reg tx_en, // byte valid
  output reg tx_er, // symbol error marker
  output reg tx_last, // final byte of frame
  input wire tx_ready, // copper side takes byte
  input wire [7:0] rx_data, // received byte
  input wire rx_dv, // received byte valid
  input wire rx_last, // received final byte
  output reg stub_test // port in stub test
);
  // =====================================
  // registers
  reg [15:0] gen_ctrl_r;
  reg [15:0] chk_ctrl_r;
  reg [7:0] pkt_cnt_r;
  reg [7:0] crc_err_cnt_r;
  reg busy_r;
  reg [7:0] sent_r;
  reg [10:0] byte_r;
  reg [15:0] lfsr_r;
  reg [31:0] tx_crc_r;
  reg [1:0] tx_fcs_r;
  reg pat_sel_r;
  reg [31:0] rx_crc_r;
  reg [7:0] rxd_r;
  reg rxv_r;
  reg rxl_r;
  reg stop_r;
  wire [7:0] burst;
  wire gen_on;
  wire continuous;
  wire trig_rd;
  wire setup_ok;
  wire wr_gen;
  wire wr_chk;
  wire mapped;
  wire [10:0] frame_len;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [9:0] fifo_out;
  reg [9:0] gen_word;
  reg [7:0] gen_byte;
  wire gen_push;
  wire frame_end;
  wire [31:0] tx_crc_nxt;
  wire [31:0] rx_crc_nxt;
  // crc-32 reflected, one byte per step
  function [31:0] crc_step;
    input [31:0] c;
    input [7:0] d;
    reg [31:0] t;
    integer k;
    begin
      t = c ^ {24'h00_0000, d};
      for (k = 0; k < 8; k = k + 1) begin
        t = t[0] ? ((t >> 1) ^ `PGC_CRC_POLY) : (t >> 1);
      end
      crc_step = t;
    end
  endfunction
  // =====================================
  // field decode
  assign burst = gen_ctrl_r[`PGC_F_BURST_HI:`PGC_F_BURST_LO];
  assign gen_on = gen_ctrl_r[`PGC_F_GEN_EN];
  assign continuous = (burst == 8'h00);
  // trigger reads done whenever not busy; a retrigger needs self-clear, enable and a nonzero burst
  assign setup_ok = gen_ctrl_r[`PGC_F_SELFCLR] && gen_on && !continuous;
  assign trig_rd = !busy_r;
  assign frame_len = gen_ctrl_r[`PGC_F_LONG] ? `PGC_LEN_LONG : `PGC_LEN_SHORT;
  assign mapped = (paddr == `PGC_ADDR_GEN_CTRL) || (paddr == `PGC_ADDR_COUNTERS) ||
                  (paddr == `PGC_ADDR_CHK_CTRL);
  assign wr_gen = psel && penable && pready && pwrite && (paddr == `PGC_ADDR_GEN_CTRL);
  assign wr_chk = psel && penable && pready && pwrite && (paddr == `PGC_ADDR_CHK_CTRL);
  // =====================================
  // apb slave: one wait state, answer at second access edge
  always @(posedge ref_clk) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !mapped;
      prdata <= 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          `PGC_ADDR_GEN_CTRL: prdata <= {16'h0000, gen_ctrl_r[15:8], trig_rd,
                                          gen_ctrl_r[6:0]};
          `PGC_ADDR_COUNTERS: prdata <= {16'h0000, pkt_cnt_r, crc_err_cnt_r};
          `PGC_ADDR_CHK_CTRL: prdata <= {16'h0000, chk_ctrl_r};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end
  // =====================================
  // control registers and burst sequencing
  // a stop or a burst end waits for the last byte, so the link never sees a cut frame
  always @(posedge ref_clk) begin
    if (reset) begin
      gen_ctrl_r <= `PGC_RST_GEN_CTRL;
      chk_ctrl_r <= `PGC_RST_CHK_CTRL;
      busy_r <= 1'b0;
      stop_r <= 1'b0;
      stub_test <= 1'b0;
    end else begin
      stub_test <= chk_ctrl_r[`PGC_F_STUB];
      if (wr_chk) begin
        chk_ctrl_r <= {pwdata[15:5], 1'b0, pwdata[3:0]}; // reset bit self-clears
      end
      if (busy_r && frame_end && (stop_r || (!continuous && (sent_r + 8'h01 == burst)))) begin
        busy_r <= 1'b0; // last frame of burst out
        stop_r <= 1'b0;
        if (!gen_ctrl_r[`PGC_F_SELFCLR]) begin
          gen_ctrl_r[`PGC_F_GEN_EN] <= 1'b0; // self-clear back to normal
        end
      end
      // the write comes last so it wins over a burst end in the same cycle
      if (wr_gen) begin
        // trigger bit is not stored; it is the inverse of busy
        gen_ctrl_r <= {pwdata[15:8], 1'b0, pwdata[6:0]};
        // enable rising from 0, or a 0 trigger write while done in set-up burst mode, starts a run
        if (pwdata[`PGC_F_GEN_EN] && !gen_on) begin
          busy_r <= 1'b1;
          stop_r <= 1'b0;
        end else if (!pwdata[`PGC_F_GEN_EN]) begin
          stop_r <= busy_r; // finish the frame in flight, then stop
        end else if (trig_rd && !pwdata[`PGC_F_TRIG] && setup_ok) begin
          busy_r <= 1'b1; // retrigger on write of 0 while done
          stop_r <= 1'b0;
        end
        // writes while busy leave the trigger alone
      end
    end
  end
  // =====================================
  // frame builder: payload then four fcs bytes
  assign tx_crc_nxt = crc_step(tx_crc_r, gen_byte);
  assign gen_push = busy_r && fifo_in_ready;
  assign frame_end = gen_push && (byte_r == frame_len - 11'h001);
  always @* begin
    gen_byte = pat_sel_r ? `PGC_PAT_B : `PGC_PAT_A;
    if (!gen_ctrl_r[`PGC_F_PATTERN]) begin
      gen_byte = lfsr_r[7:0];
    end
    gen_word = {1'b0, 1'b0, gen_byte};
    // last four bytes carry the inverted crc, low byte first
    if (byte_r >= frame_len - 11'h004) begin
      gen_word = {1'b0, 1'b0, ~tx_crc_r[7:0]};
      // corrupt fcs and flag a symbol error on errored frames
      if (gen_ctrl_r[`PGC_F_ERR]) begin
        gen_word = {1'b0, 1'b1, ~tx_crc_r[7:0] ^ `PGC_ERR_BYTE};
      end
    end
    if (frame_end) begin
      gen_word[9] = 1'b1;
    end
  end
  // byte counter, lfsr, pattern toggle and running crc
  always @(posedge ref_clk) begin
    if (reset || !busy_r) begin
      byte_r <= 11'h000;
      lfsr_r <= `PGC_LFSR_SEED;
      pat_sel_r <= 1'b0;
      tx_crc_r <= `PGC_CRC_INIT;
      if (reset || (wr_gen && busy_r == 1'b0)) begin
        sent_r <= 8'h00;
      end
    end else if (gen_push) begin
      pat_sel_r <= !pat_sel_r;
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      if (byte_r >= frame_len - 11'h004) begin
        tx_crc_r <= {8'h00, tx_crc_r[31:8]}; // shift fcs bytes out
      end else begin
        tx_crc_r <= tx_crc_nxt;
      end
      if (frame_end) begin
        byte_r <= 11'h000;
        tx_crc_r <= `PGC_CRC_INIT;
        pat_sel_r <= 1'b0;
        sent_r <= sent_r + 8'h01;
      end else begin
        byte_r <= byte_r + 11'h001;
      end
    end
  end
  // =====================================
  // transmit fifo, drained by the copper side
  pgc_fifo #(
    .WIDTH(10),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(ref_clk),
    .rst(reset),
    .in_data(gen_word),
    .in_valid(gen_push),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(tx_ready && !(tx_en && !tx_ready))
  );
  // output stage registers, one byte per accepted handshake
  always @(posedge ref_clk) begin
    if (reset) begin
      tx_data <= 8'h00;
      tx_en <= 1'b0;
      tx_er <= 1'b0;
      tx_last <= 1'b0;
    end else if (!tx_en || tx_ready) begin
      tx_en <= fifo_out_valid && tx_ready;
      tx_data <= fifo_out[7:0];
      tx_er <= fifo_out_valid && tx_ready && fifo_out[8];
      tx_last <= fifo_out_valid && tx_ready && fifo_out[9];
    end
  end
  // =====================================
  // receive checker; rx pins pass two flops first
  reg [7:0] rxd_m;
  reg rxv_m;
  reg rxl_m;
  assign rx_crc_nxt = crc_step(rx_crc_r, rxd_r);
  always @(posedge ref_clk) begin
    if (reset) begin
      rxd_m <= 8'h00;
      rxv_m <= 1'b0;
      rxl_m <= 1'b0;
      rxd_r <= 8'h00;
      rxv_r <= 1'b0;
      rxl_r <= 1'b0;
    end else begin
      rxd_m <= rx_data;
      rxv_m <= rx_dv;
      rxl_m <= rx_last;
      rxd_r <= rxd_m;
      rxv_r <= rxv_m;
      rxl_r <= rxl_m;
    end
  end
  // counters saturate at ff; counter reset wins over a count
  always @(posedge ref_clk) begin
    if (reset || (wr_chk && pwdata[`PGC_F_CNT_RST])) begin
      pkt_cnt_r <= 8'h00;
      crc_err_cnt_r <= 8'h00;
      rx_crc_r <= `PGC_CRC_INIT;
    end else if (rxv_r && gen_ctrl_r[`PGC_F_CHK_EN]) begin
      rx_crc_r <= rx_crc_nxt;
      if (rxl_r) begin
        rx_crc_r <= `PGC_CRC_INIT;
        if (pkt_cnt_r != 8'hFF) begin
          pkt_cnt_r <= pkt_cnt_r + 8'h01;
        end
        if ((rx_crc_nxt != `PGC_CRC_RESIDUE) && (crc_err_cnt_r != 8'hFF)) begin
          crc_err_cnt_r <= crc_err_cnt_r + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- src/pgc_consts.vh ----
// register map, field positions and sizes for the packet generator / crc checker
`ifndef PGC_CONSTS_VH
`define PGC_CONSTS_VH
// register indices as printed; byte address is four times the index
`define PGC_IDX_GEN_CTRL 8'h10
`define PGC_IDX_COUNTERS 8'h11
`define PGC_IDX_CHK_CTRL 8'h12
`define PGC_ADDR_GEN_CTRL 12'h040
`define PGC_ADDR_COUNTERS 12'h044
`define PGC_ADDR_CHK_CTRL 12'h048
// generator control fields
`define PGC_F_BURST_HI 15
`define PGC_F_BURST_LO 8
`define PGC_F_TRIG 7
`define PGC_F_SELFCLR 6
`define PGC_F_CHK_EN 4
`define PGC_F_GEN_EN 3
`define PGC_F_PATTERN 2
`define PGC_F_LONG 1
`define PGC_F_ERR 0
// checker control fields
`define PGC_F_CNT_RST 4
`define PGC_F_STUB 3
// reset values
`define PGC_RST_GEN_CTRL 16'h0000
`define PGC_RST_CHK_CTRL 16'h0000
// frame lengths in bytes, fixed payload bytes, lfsr seed, crc constants and fcs error mask
`define PGC_LEN_SHORT 11'h040
`define PGC_LEN_LONG 11'h5EE
`define PGC_PAT_A 8'h5A
`define PGC_PAT_B 8'hA5
`define PGC_LFSR_SEED 16'hACE1
`define PGC_CRC_INIT 32'hFFFF_FFFF
`define PGC_CRC_POLY 32'hEDB8_8320
`define PGC_CRC_RESIDUE 32'hDEBB_20E3
`define PGC_ERR_BYTE 8'hFE
`endif

// ---- src/pgc_fifo.v ----
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pgc_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk, // clock
  input wire rst, // sync reset, active high
  input wire [WIDTH-1:0] in_data, // write data
  input wire in_valid, // write request
  output wire in_ready, // not full
  output wire [WIDTH-1:0] out_data, // head word
  output wire out_valid, // not empty
  input wire out_ready // consumer takes head
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire push;
  wire pop;
  // =====================================
  // flags
  assign in_ready = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = mem_r[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // pointers wrap, so depth should be a power of two
  always @(posedge clk) begin
    if (rst) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
  // storage, no reset needed
  always @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ---- dv/pgc_checker_assertions.sv ----
// concurrent checks on the generator and checker ports
`timescale 1ns/1ps
`default_nettype none
module pgc_checker (
  input wire logic ref_clk, // clock
  input wire logic reset, // sync reset
  input wire logic psel, // apb select
  input wire logic penable, // access phase
  input wire logic pwrite, // direction
  input wire logic [11:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic [7:0] tx_data, // tx byte
  input wire logic tx_en, // tx valid
  input wire logic tx_er, // symbol error
  input wire logic tx_last, // last byte
  input wire logic tx_ready, // far side ready
  input wire logic stub_test // stub mode
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ==========
  // byte position and shadow of written settings
  logic [10:0] pos_r;
  logic pat_r;
  logic stub_r;
  wire take = tx_en && tx_ready;
  wire done_x = psel && penable && pready;
  // position restarts after each final byte
  always @(posedge ref_clk) begin
    if (reset) begin
      pos_r <= 11'h000;
      pat_r <= 1'b0;
      stub_r <= 1'b0;
    end else begin
      if (take)
        pos_r <= tx_last ? 11'h000 : pos_r + 11'h001;
      if (done_x && pwrite && paddr == 12'h040)
        pat_r <= pwdata[2];
      if (done_x && pwrite && paddr == 12'h048)
        stub_r <= pwdata[3];
    end
  end
  // ==========
  // properties
  a_tx_hold: assert property (tx_en && !tx_ready |=> tx_en && $stable(tx_data))
    else $error("tx byte changed before it was taken");
  a_frame_len: assert property (take && tx_last |-> pos_r == 11'h03F || pos_r == 11'h5ED)
    else $error("frame length wrong");
  a_last_valid: assert property (tx_last |-> tx_en)
    else $error("final marker without valid");
  a_pat_bytes: assert property (take && pat_r && pos_r < 11'h03C |->
    tx_data == (pos_r[0] ? 8'hA5 : 8'h5A))
    else $error("fixed payload byte wrong");
  a_er_fcs: assert property (take && tx_er |-> pos_r >= 11'h03C)
    else $error("symbol error outside fcs");
  a_stub_follow: assert property (done_x && pwrite && paddr == 12'h048 |=> ##1 stub_test == stub_r)
    else $error("stub output not following register");
  a_cnt_rst_rd: assert property (done_x && !pwrite && paddr == 12'h048 |-> !prdata[4])
    else $error("counter reset bit read back set");
  a_rd_upper: assert property (done_x && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
endmodule
bind pgc_top pgc_checker chk (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .tx_data, .tx_en, .tx_er, .tx_last, .tx_ready, .stub_test);
`default_nettype wire

// ---- dv/pgc_link_model.sv ----
// copper link partner that takes generated frames and loops them back
`timescale 1ns/1ps
`default_nettype none
module pgc_link_model (
  input wire logic clk, // clock
  input wire logic rst, // sync reset
  input wire logic slow, // stall every other cycle
  input wire logic [7:0] tx_data, // generated byte
  input wire logic tx_en, // byte valid
  input wire logic tx_er, // symbol error
  input wire logic tx_last, // final byte
  output logic tx_ready, // accept
  output logic [7:0] rx_data, // returned byte
  output logic rx_dv, // returned valid
  output logic rx_last, // returned final
  output var int frames, // frames seen
  output var int len_last, // last frame length
  output var int er_bytes, // errored bytes
  output logic [15:0] head // first two bytes
);
  int cnt;
  logic tog_r;
  wire take = tx_en && tx_ready;
  // stalling on alternate cycles lets the fifo fill
  assign tx_ready = !slow || tog_r;
  // idle rx data toggles so a stale byte never looks valid
  always @(posedge clk) begin
    tog_r <= rst ? 1'b0 : !tog_r;
    rx_dv <= !rst && take;
    rx_last <= !rst && take && tx_last;
    rx_data <= rst ? 8'h00 : (take ? tx_data : ~rx_data);
    if (rst) begin
      cnt <= 0;
      frames <= 0;
      er_bytes <= 0;
    end else if (take) begin
      cnt <= tx_last ? 0 : cnt + 1;
      if (cnt == 0)
        head[15:8] <= tx_data;
      if (cnt == 1)
        head[7:0] <= tx_data;
      if (tx_er)
        er_bytes <= er_bytes + 1;
      if (tx_last) begin
        frames <= frames + 1;
        len_last <= cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- dv/test_pgc_top.sv ----
// self-checking bench for the packet generator and crc checker
`include "pgc_consts.vh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_pgc_top;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0, serr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, q;
  wire [31:0] prdata;
  wire pready, pslverr, tx_en, tx_er, tx_last, tx_ready, rx_dv, rx_last, stub_test;
  wire [7:0] tx_data, rx_data;
  wire [15:0] head;
  int frames, len_last, er_bytes, fail_count = 0, comparisons = 0;
  pgc_top dut (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .tx_data, .tx_en, .tx_er, .tx_last, .tx_ready, .rx_data,
    .rx_dv, .rx_last, .stub_test);
  pgc_link_model link (.clk(ref_clk), .rst(reset), .slow, .tx_data, .tx_en, .tx_er,
    .tx_last, .tx_ready, .rx_data, .rx_dv, .rx_last, .frames, .len_last, .er_bytes, .head);
  // ==========
  // verdict and bus tasks
  task automatic end_sim;
    if (fail_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // one apb transfer; held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      end_sim();
    end
    @(posedge ref_clk);
  endtask
  // bounded waits on the partner's frame count and on the done flag
  task automatic wait_frames(input int n);
    int i;
    for (i = 0; i < 20000 && frames < n; i++)
      @(posedge ref_clk);
    if (frames < n) begin
      fail_count++;
      end_sim();
    end
  endtask
  task automatic wait_done;
    int i;
    q = 32'h0000_0000;
    for (i = 0; i < 200 && q[7] !== 1'b1; i++)
      apb(1'b0, `PGC_ADDR_GEN_CTRL, 32'h0000_0000);
    if (q[7] !== 1'b1) begin
      fail_count++;
      end_sim();
    end
  endtask
  initial forever #4 ref_clk = ~ref_clk;
  // ==========
  // scenarios
  initial begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    apb(1'b0, `PGC_ADDR_GEN_CTRL, 32'h0000_0000);
    `CHK(q, 32'h0000_0080)
    apb(1'b0, `PGC_ADDR_COUNTERS, 32'h0000_0000);
    `CHK(q, 32'h0000_0000)
    apb(1'b0, 12'h04C, 32'h0000_0000);
    `CHK(serr, 1'b1)
    // burst of two fixed-pattern short frames, looped back and counted
    apb(1'b1, `PGC_ADDR_GEN_CTRL, 32'h0000_025C);
    apb(1'b0, `PGC_ADDR_GEN_CTRL, 32'h0000_0000);
    `CHK(q[7], 1'b0)
    wait_frames(2);
    wait_done();
    `CHK(q[3], 1'b1)
    `CHK(frames, 2)
    `CHK(len_last, 64)
    `CHK(head, 16'h5AA5)
    apb(1'b0, `PGC_ADDR_COUNTERS, 32'h0000_0000);
    `CHK(q, 32'h0000_0200)
    // retrigger, then writes while busy must not add a burst
    apb(1'b1, `PGC_ADDR_GEN_CTRL, 32'h0000_025C);
    apb(1'b1, `PGC_ADDR_GEN_CTRL, 32'h0000_02DC);
    apb(1'b1, `PGC_ADDR_GEN_CTRL, 32'h0000_025C);
    wait_frames(4);
    wait_done();
    repeat (300) @(posedge ref_clk);
    `CHK(frames, 4)
    // one errored frame without self-clear
    apb(1'b1, `PGC_ADDR_GEN_CTRL, 32'h0000_0010);
    apb(1'b1, `PGC_ADDR_GEN_CTRL, 32'h0000_0119);
    wait_frames(5);
    wait_done();
    `CHK(q[3], 1'b0)
    `CHK(er_bytes, 4)
    apb(1'b0, `PGC_ADDR_COUNTERS, 32'h0000_0000);
    `CHK(q, 32'h0000_0501)
    // counter reset with stub test on, then off
    apb(1'b1, `PGC_ADDR_CHK_CTRL, 32'h0000_0018);
    apb(1'b0, `PGC_ADDR_CHK_CTRL, 32'h0000_0000);
    `CHK(q, 32'h0000_0008)
    `CHK(stub_test, 1'b1)
    apb(1'b0, `PGC_ADDR_COUNTERS, 32'h0000_0000);
    `CHK(q, 32'h0000_0000)
    apb(1'b1, `PGC_ADDR_CHK_CTRL, 32'h0000_0000);
    @(posedge ref_clk);
    `CHK(stub_test, 1'b0)
    // long frame with a stalling partner, checker off
    slow <= 1'b1;
    apb(1'b1, `PGC_ADDR_GEN_CTRL, 32'h0000_0000);
    apb(1'b1, `PGC_ADDR_GEN_CTRL, 32'h0000_010A);
    wait_frames(6);
    wait_done();
    `CHK(len_last, 1518)
    apb(1'b0, `PGC_ADDR_COUNTERS, 32'h0000_0000);
    `CHK(q, 32'h0000_0000)
    // continuous mode keeps going past any burst, enable stays set
    slow <= 1'b0;
    apb(1'b1, `PGC_ADDR_GEN_CTRL, 32'h0000_0048);
    wait_frames(9);
    apb(1'b0, `PGC_ADDR_GEN_CTRL, 32'h0000_0000);
    `CHK(q[3], 1'b1)
    // stopping finishes the frame in flight at full length
    apb(1'b1, `PGC_ADDR_GEN_CTRL, 32'h0000_0000);
    wait_done();
    `CHK(q[3], 1'b0)
    repeat (100) @(posedge ref_clk);
    `CHK(len_last, 64)
    end_sim();
  end
endmodule
`default_nettype wire
